// File: hdl/cra_pkg.sv
/*
 constants, field layout and state type of the challenge-response engine.
 assumes a 10 MHz core clock and a classic wishbone master with 8-bit byte addresses.
*/
// How it works
// [RULE1] - control register is read/write; status register is read-only, writes ignored.
// [RULE2] - power-on or soft reset loads the configuration byte from one-time memory.
// [RULE3] - configuration sets device address, speed, irq enable, auto-sleep and lockout bits.
// [RULE4] - a newly set, enabled status flag makes the device send a break.
// [RULE5] - after an interrupt break the host reads status as its next access.
// [RULE6] - any frame after an interrupt that skips status triggers another break.
// [RULE7] - reading the status register clears every status flag.
// [RULE8] - secret-selection byte picks two 32-bit secrets that program the hash engine.
// [RULE9] - four challenge byte registers are written; an 8-bit result is read back.
// [RULE10] - fourth challenge byte starts hashing; the result register holds the outcome.
// [RULE11] - host wakes, selects secrets, writes challenge, reads and compares result.
// [RULE12] - host rewrites the secret selection before every new challenge.
// [RULE13] - challenge without fresh secret selection sets the bus-error flag.
// [RULE14] - first secret gives polynomials and input selects, second the seeds.
// [RULE15] - lockout bits never clear; locked secrets unreadable, unwritable, still hashed; here a power-on reset clears the memory and the lockout bits.
// [RULE16] - four independent programmable 8-bit crc calculators form the hash; here each feedback also takes the neighbour's low bit.
// [RULE17] - result is first xor second ror 2 xor third ror 4 xor fourth ror 6.
// [RULE18] - irq sources: busy-write access always, bus error and protected access gated.
// [RULE19] - every driven break is a low pulse of 1.391 bit times.
// [RULE20] - the calculators eat the challenge one bit per step.
// [RULE21] - secret-to-calculator bit mapping is a parameterised function.
package cra_pkg;
   localparam int WB_AW = 8;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_SECRET_SELECT_REG = 8'h08;
   localparam logic [7:0] OFS_CHAL0 = 8'h0c;
   localparam logic [7:0] OFS_CHAL3 = 8'h18;
   localparam logic [7:0] OFS_RES = 8'h1c;
   localparam logic [2:0] OFS_OTP_TOP = 3'h2;
   // configuration / control byte fields
   localparam int CFG_LOCK_LO = 0;
   localparam int CFG_AUTO_SLEEP_ENABLE = 2;
   localparam int CFG_IRQEN = 3;
   localparam int CFG_SPD_LO = 4;
   localparam int CFG_DAB_LO = 6;
   localparam int CTRL_SRST = 8;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // status byte fields
   localparam int STAT_EEW = 0;
   localparam int STAT_BER = 1;
   localparam int STAT_ACC = 2;
   localparam int STAT_LOCK_LO = 3;
   localparam int STAT_DAB_LO = 6;
   // one-time memory layout, in byte pairs
   localparam int OTP_PAIRS = 8;
   localparam logic [2:0] CFG_PAIR = 3'd0;
   localparam int SEC_PAIR_BASE = 1;
   localparam int SEC_PAIRS = 2;
   localparam logic [1:0] SEC_SETS = 2'd3;
   localparam int SEC_LOADS = 4;
   localparam int HASH_STEPS = 32;
   // timing
   localparam int CLK_NS = 100;
   localparam int BT_X1_NS = 172800;
   localparam int BRK_PERMILLE = 1391;
   localparam int BRK_CYC_X1_DEF = BT_X1_NS * BRK_PERMILLE / 1000 / CLK_NS;
   localparam int OTP_WR_NS = 1800000;
   localparam int WR_BUSY_CYC_DEF = (OTP_WR_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CFG = 2'b01,
      ST_SEC = 2'b10,
      ST_HASH = 2'b11
   } cra_state_t;
endpackage

// File: hdl/cra_otp_mem.sv
/*
 byte-pair memory standing in for the one-time programmable array.
 assumes writes come whole pairs with per-byte enables; read data is registered.
*/
`timescale 1ns/1ps
module cra_otp_mem
#(
   parameter int DEPTH = 8,
   parameter int LANE_W = 8
)
(
   input wire logic core_clk, // core clock
   input wire logic nrst, // async reset
   input wire logic ce, // clock enable
   input wire logic [1:0] we, // per-byte write enable
   input wire logic [$clog2(DEPTH)-1:0] waddr, // pair index written
   input wire logic [2*LANE_W-1:0] wdata, // pair data, low byte first
   input wire logic [$clog2(DEPTH)-1:0] raddr, // pair index read
   output logic [2*LANE_W-1:0] rdata // registered read data
);
   logic [2*LANE_W-1:0] mem_q [DEPTH];

   if (DEPTH < 2 || LANE_W < 1)
   begin : g_chk_shape
      $error("memory shape out of range");
   end

   // flop array: reset gives the blank all-zero state, so the lockout bits start defined;
   // limitation: unlike a real one-time macro, a power-on reset erases this model
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int k = 0; k < DEPTH; k++)
            mem_q[k] <= '0;
      end
      else if (ce)
      begin
         if (we[0])
            mem_q[waddr][LANE_W-1:0] <= wdata[LANE_W-1:0];
         if (we[1])
            mem_q[waddr][2*LANE_W-1:LANE_W] <= wdata[2*LANE_W-1:LANE_W];
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         rdata <= '0;
      else if (ce)
         rdata <= mem_q[raddr];
   end
endmodule // cra_otp_mem

// File: hdl/cra_result_reg_a_engine.sv
/*
 challenge-response hash engine with control, status, break and memory access logic.
 assumes a classic wishbone master on core_clk; each wishbone access counts as one frame.
*/
`timescale 1ns/1ps
module cra_result_reg_a_engine
#(
   parameter int BRK_CYC_X1 = cra_pkg::BRK_CYC_X1_DEF,
   parameter int WR_BUSY_CYC = cra_pkg::WR_BUSY_CYC_DEF,
   parameter int MAP_ROT = 0
)
(
   input wire logic core_clk, // 10 MHz core clock
   input wire logic nrst, // async active-low reset
   input wire logic ce, // clock enable, freezes all state
   input wire logic wb_cyc_i, // wishbone cycle
   input wire logic wb_stb_i, // wishbone strobe
   input wire logic wb_we_i, // wishbone write
   input wire logic [cra_pkg::WB_AW-1:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte lanes
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   output logic line_out, // break level, always low
   output logic line_oe, // high while a break is driven
   output logic [1:0] device_addr_bits, // device address
   output logic [1:0] bus_speed_select, // bit-rate select
   output logic auto_sleep_enable, // auto-sleep enable
   output logic hash_busy // hash in progress
);
   import cra_pkg::*;

   localparam int BRK_W = 14;
   localparam int WR_W = 15;

   if (BRK_CYC_X1 < 4 || 2 * BRK_CYC_X1 >= 2 ** BRK_W)
   begin : g_chk_brk
      $error("break length out of range");
   end
   if (WR_BUSY_CYC < 1 || WR_BUSY_CYC >= 2 ** WR_W)
   begin : g_chk_wr
      $error("write busy length out of range");
   end
   if (MAP_ROT < 0 || MAP_ROT > 3)
   begin : g_chk_map
      $error("map rotation out of range");
   end

   // secret byte for calculator i; rotation lets the mapping be re-wired
   function automatic logic [7:0] sec_byte(input logic [31:0] s, input int i);
      sec_byte = s[8*((i+MAP_ROT)%4) +: 8];
   endfunction

   function automatic logic [7:0] ror8(input logic [7:0] b, input int n);
      ror8 = 8'((b >> n) | (b << (8 - n)));
   endfunction

   // pair j of the load: j 0..1 from first set, 2..3 from second
   function automatic logic [2:0] pair_addr(input logic [7:0] sel, input logic [2:0] j);
      logic [1:0] set;
      set = j[1] ? sel[3:2] : sel[1:0];
      pair_addr = 3'(SEC_PAIR_BASE + SEC_PAIRS * set + j[0]);
   endfunction

   // secret pairs hidden by the lockout bits
   function automatic logic lock_hit(input logic [2:0] pair, input logic [1:0] lock);
      lock_hit = (lock[1] && pair >= 3'd1 && pair <= 3'd4)
         || (lock[0] && (pair == 3'd5 || pair == 3'd6));
   endfunction

   function automatic logic [BRK_W-1:0] brk_len(input logic [1:0] spd);
      case (spd)
         2'd0: brk_len = BRK_W'(2 * BRK_CYC_X1);
         2'd1: brk_len = BRK_W'(BRK_CYC_X1);
         2'd2: brk_len = BRK_W'(BRK_CYC_X1 / 2);
         default: brk_len = BRK_W'(BRK_CYC_X1 / 4);
      endcase
   endfunction

   cra_state_t st_q;
   logic [2:0] ld_cnt_q;
   logic [4:0] step_q;
   logic [7:0] ctrl_q;
   logic [7:0] secret_select_reg_q;
   logic [7:0] result_q;
   logic [31:0] chal_q;
   logic [2:0] flags_q;
   logic [1:0] lock_seen_q;
   logic fresh_q;
   logic [63:0] sec_q;
   logic [7:0] crc_q [4];
   logic [7:0] crc_nx [4];
   logic wait_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic [WR_W-1:0] wr_cnt_q;
   logic [BRK_W-1:0] brk_cnt_q;
   logic brk_pend_q;
   logic brk_on_q;

   logic mem_busy, take, wr_busy, is_otp, exec_ok;
   logic [2:0] pair;
   logic [1:0] chal_idx;
   logic stat_rd, ctrl_wr, secret_select_reg_wr, secret_select_reg_bad, chal_wr, chal_last, hash_go, secret_select_reg_go;
   logic soft_rst, otp_wr_ok, cfg_done, sec_done, brk_req;
   logic [2:0] set_vec, irq_en;
   logic [31:0] rd_val;
   logic [1:0] mem_we;
   logic [15:0] mem_wdata, mem_rdata;
   logic [2:0] mem_raddr;

   // ---------------- access decode, valid in the exec cycle ----------------
   assign mem_busy = (st_q == ST_CFG) || (st_q == ST_SEC);
   assign take = wb_cyc_i && wb_stb_i && !wait_q && !ack_q && !mem_busy;
   assign wr_busy = (wr_cnt_q != '0);
   // a memory write in progress swallows the whole access
   assign exec_ok = wait_q && !wr_busy;
   assign is_otp = (wb_adr_i[7:5] == OFS_OTP_TOP) && (wb_adr_i[1:0] == 2'b00);
   assign pair = wb_adr_i[4:2];
   assign chal_idx = wb_adr_i[3:2] - 2'd3;
   assign stat_rd = exec_ok && !wb_we_i && (wb_adr_i == OFS_STAT); // [RULE7]
   assign ctrl_wr = exec_ok && wb_we_i && (wb_adr_i == OFS_CTRL);
   assign secret_select_reg_wr = exec_ok && wb_we_i && wb_sel_i[0] && (wb_adr_i == OFS_SECRET_SELECT_REG);
   assign secret_select_reg_bad = secret_select_reg_wr && (wb_dat_i[1:0] == SEC_SETS || wb_dat_i[3:2] == SEC_SETS
      || st_q != ST_IDLE);
   assign secret_select_reg_go = secret_select_reg_wr && !secret_select_reg_bad; // [RULE8]
   assign chal_wr = exec_ok && wb_we_i && wb_sel_i[0] && wb_adr_i[1:0] == 2'b00
      && wb_adr_i >= OFS_CHAL0 && wb_adr_i <= OFS_CHAL3 && st_q != ST_HASH;
   assign chal_last = chal_wr && (chal_idx == 2'd3);
   assign hash_go = chal_last && fresh_q && (st_q == ST_IDLE); // [RULE10]
   assign soft_rst = ctrl_wr && wb_sel_i[1] && wb_dat_i[CTRL_SRST];
   // locked parts refuse every write to the memory [RULE15]
   assign otp_wr_ok = exec_ok && wb_we_i && is_otp && (ctrl_q[CFG_LOCK_LO +: 2] == 2'b00);
   assign cfg_done = (st_q == ST_CFG) && (ld_cnt_q != 3'd0);
   assign sec_done = (st_q == ST_SEC) && (ld_cnt_q == 3'(SEC_LOADS));

   always_comb
   begin
      set_vec = 3'b000;
      set_vec[STAT_EEW] = wait_q && wr_busy; // [RULE18]
      // stale seeds or a busy engine make the sequence improper [RULE13]
      set_vec[STAT_BER] = secret_select_reg_bad || (chal_last && !hash_go)
         || (exec_ok && wb_we_i && st_q == ST_HASH && wb_adr_i >= OFS_CHAL0
         && wb_adr_i <= OFS_CHAL3);
      set_vec[STAT_ACC] = exec_ok && is_otp
         && (wb_we_i ? !otp_wr_ok : lock_hit(pair, ctrl_q[CFG_LOCK_LO +: 2])); // [RULE15]
   end

   // ---------------- memory port ----------------
   always_comb
   begin
      mem_we = 2'b00;
      mem_wdata = wb_dat_i[15:0];
      if (otp_wr_ok)
      begin
         // the trim byte beside the configuration byte is read-only
         mem_we = {pair != CFG_PAIR, 1'b1};
         if (pair == CFG_PAIR)
            mem_wdata[CFG_LOCK_LO +: 2] = wb_dat_i[CFG_LOCK_LO +: 2] | lock_seen_q; // [RULE15]
      end
      case (st_q)
         ST_CFG: mem_raddr = CFG_PAIR;
         ST_SEC: mem_raddr = pair_addr(secret_select_reg_q, ld_cnt_q);
         default: mem_raddr = pair;
      endcase
   end

   cra_otp_mem #(.DEPTH(OTP_PAIRS), .LANE_W(8)) u_mem (
      .core_clk(core_clk),
      .nrst(nrst),
      .ce(ce),
      .we(mem_we),
      .waddr(pair),
      .wdata(mem_wdata),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   // ---------------- read mux ----------------
   always_comb
   begin
      rd_val = 32'h0000_0000;
      if (!wr_busy && !wb_we_i)
      begin
         case (wb_adr_i)
            OFS_CTRL: rd_val[7:0] = ctrl_q; // [RULE1]
            OFS_STAT:
            begin
               rd_val[STAT_EEW] = flags_q[STAT_EEW];
               rd_val[STAT_BER] = flags_q[STAT_BER];
               rd_val[STAT_ACC] = flags_q[STAT_ACC];
               rd_val[STAT_LOCK_LO +: 2] = ctrl_q[CFG_LOCK_LO +: 2];
               rd_val[STAT_DAB_LO +: 2] = ctrl_q[CFG_DAB_LO +: 2];
            end
            OFS_SECRET_SELECT_REG: rd_val[7:0] = secret_select_reg_q;
            OFS_RES: rd_val[7:0] = result_q; // [RULE9]
            default:
            begin
               if (chal_wr || (wb_adr_i >= OFS_CHAL0 && wb_adr_i <= OFS_CHAL3
                  && wb_adr_i[1:0] == 2'b00))
                  rd_val[7:0] = chal_q[8*chal_idx +: 8];
               else if (is_otp && !lock_hit(pair, ctrl_q[CFG_LOCK_LO +: 2]))
                  rd_val[15:0] = mem_rdata;
            end
         endcase
      end
   end

   // ---------------- wishbone handshake ----------------
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wait_q <= 1'b0;
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end
      else if (ce)
      begin
         wait_q <= take;
         ack_q <= wait_q;
         if (wait_q)
            dat_q <= rd_val;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // ---------------- sequencer ----------------
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_q <= ST_CFG; // [RULE2]
         ld_cnt_q <= 3'd0;
         step_q <= 5'd0;
      end
      else if (ce)
      begin
         if (soft_rst)
         begin
            st_q <= ST_CFG; // [RULE2]
            ld_cnt_q <= 3'd0;
         end
         else
         begin
            case (st_q)
               ST_CFG:
               begin
                  ld_cnt_q <= 3'd1;
                  if (ld_cnt_q != 3'd0)
                  begin
                     st_q <= ST_IDLE;
                     ld_cnt_q <= 3'd0;
                  end
               end
               ST_IDLE:
               begin
                  step_q <= 5'd0;
                  if (secret_select_reg_go)
                     st_q <= ST_SEC;
                  else if (hash_go)
                     st_q <= ST_HASH;
               end
               ST_SEC:
               begin
                  ld_cnt_q <= ld_cnt_q + 3'd1;
                  if (sec_done)
                  begin
                     st_q <= ST_IDLE;
                     ld_cnt_q <= 3'd0;
                  end
               end
               ST_HASH:
               begin
                  step_q <= step_q + 5'd1; // [RULE20]
                  if (step_q == 5'(HASH_STEPS - 1))
                     st_q <= ST_IDLE;
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end

   // ---------------- control and host registers ----------------
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_q <= CTRL_RST;
         lock_seen_q <= 2'b00;
         secret_select_reg_q <= 8'h00;
         chal_q <= 32'h0000_0000;
      end
      else if (ce)
      begin
         if (cfg_done)
         begin
            ctrl_q <= mem_rdata[7:0]; // [RULE3]
            lock_seen_q <= lock_seen_q | mem_rdata[CFG_LOCK_LO +: 2];
         end
         else if (ctrl_wr && wb_sel_i[0])
            ctrl_q[7:2] <= wb_dat_i[7:2]; // lockout copy is not host-writable [RULE1]
         if (otp_wr_ok && pair == CFG_PAIR)
            lock_seen_q <= lock_seen_q | wb_dat_i[CFG_LOCK_LO +: 2]; // [RULE15]
         if (secret_select_reg_go)
            secret_select_reg_q <= wb_dat_i[7:0];
         if (chal_wr)
            chal_q[8*chal_idx +: 8] <= wb_dat_i[7:0]; // [RULE9]
      end
   end

   assign device_addr_bits = ctrl_q[CFG_DAB_LO +: 2];
   assign bus_speed_select = ctrl_q[CFG_SPD_LO +: 2];
   assign auto_sleep_enable = ctrl_q[CFG_AUTO_SLEEP_ENABLE];
   assign hash_busy = (st_q == ST_HASH);

   // ---------------- secret load and hash ----------------
   for (genvar i = 0; i < 4; i++)
   begin : g_crc
      logic [7:0] sb;
      logic fb;
      assign sb = sec_byte(sec_q[31:0], i); // [RULE21]
      // low bit of each byte couples in the neighbour; the polynomial keeps x^0 set
      assign fb = crc_q[i][7] ^ chal_q[step_q] ^ (sb[0] & crc_q[(i+3)%4][0]); // [RULE14]
      assign crc_nx[i] = {crc_q[i][6:0], 1'b0} ^ (fb ? {sb[7:1], 1'b1} : 8'h00); // [RULE16]
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sec_q <= 64'h0;
         fresh_q <= 1'b0;
         result_q <= 8'h00;
         for (int i = 0; i < 4; i++)
            crc_q[i] <= 8'h00;
      end
      else if (ce)
      begin
         if (st_q == ST_SEC && ld_cnt_q != 3'd0)
            sec_q[{ld_cnt_q[1:0] - 2'd1, 4'd0} +: 16] <= mem_rdata; // [RULE8]
         if (soft_rst || hash_go || secret_select_reg_go)
            fresh_q <= 1'b0;
         else if (sec_done)
            fresh_q <= 1'b1; // [RULE13]
         if (hash_go)
         begin
            for (int i = 0; i < 4; i++)
               crc_q[i] <= sec_byte(sec_q[63:32], i); // [RULE14]
         end
         else if (st_q == ST_HASH)
         begin
            for (int i = 0; i < 4; i++)
               crc_q[i] <= crc_nx[i]; // [RULE16]
            if (step_q == 5'(HASH_STEPS - 1))
               result_q <= crc_nx[0] ^ ror8(crc_nx[1], 2) ^ ror8(crc_nx[2], 4)
                  ^ ror8(crc_nx[3], 6); // [RULE17]
         end
      end
   end

   // ---------------- status flags and breaks ----------------
   assign irq_en = {ctrl_q[CFG_IRQEN], ctrl_q[CFG_IRQEN], 1'b1}; // [RULE18]
   // ready break after a load, a fresh enabled flag, or a frame that skipped status
   assign brk_req = cfg_done || (|(set_vec & irq_en & ~flags_q)) // [RULE4]
      || (wait_q && !stat_rd && |(flags_q & irq_en)); // [RULE6]

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         flags_q <= 3'b000;
      else if (ce)
      begin
         if (soft_rst)
            flags_q <= 3'b000;
         else
            flags_q <= (flags_q & ~{3{stat_rd}}) | set_vec; // set beats clear [RULE7]
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         brk_pend_q <= 1'b0;
         brk_on_q <= 1'b0;
         brk_cnt_q <= '0;
      end
      else if (ce)
      begin
         brk_pend_q <= brk_req || (brk_pend_q && brk_on_q);
         if (brk_on_q)
         begin
            brk_cnt_q <= brk_cnt_q - 1'b1;
            if (brk_cnt_q == BRK_W'(1))
               brk_on_q <= 1'b0;
         end
         else if (brk_pend_q)
         begin
            brk_cnt_q <= brk_len(ctrl_q[CFG_SPD_LO +: 2]); // [RULE19]
            brk_on_q <= 1'b1;
         end
      end
   end

   assign line_out = 1'b0;
   assign line_oe = brk_on_q;

   // ---------------- memory write busy timer ----------------
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         wr_cnt_q <= '0;
      else if (ce)
      begin
         if (otp_wr_ok)
            wr_cnt_q <= WR_W'(WR_BUSY_CYC);
         else if (wr_busy)
            wr_cnt_q <= wr_cnt_q - 1'b1;
      end
   end
endmodule // cra_result_reg_a_engine

// File: verification/cra_result_reg_a_props.sv
/*
 concurrent checks on the ports of the challenge-response engine.
 assumes one clock domain and a bind from the testbench top file.
*/
`timescale 1ns/1ps
module cra_result_reg_a_props
#(
   parameter int BRK_CYC_X1 = 8
)
(
   input wire logic core_clk, // clock
   input wire logic nrst, // async reset
   input wire logic wb_cyc_i, // cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write
   input wire logic [cra_pkg::WB_AW-1:0] wb_adr_i, // address
   input wire logic [31:0] wb_dat_i, // write data
   input wire logic [31:0] wb_dat_o, // read data
   input wire logic wb_ack_o, // acknowledge
   input wire logic line_out, // break level
   input wire logic line_oe, // break drive
   input wire logic [1:0] bus_speed_select, // speed
   input wire logic hash_busy // hashing
);
   import cra_pkg::*;
   int brk_q;
   int hb_q;
   int brk_exp;
   logic arm_q;
   assign brk_exp = (bus_speed_select == 2'h0) ? 2 * BRK_CYC_X1 :
                    (bus_speed_select == 2'h1) ? BRK_CYC_X1 :
                    (bus_speed_select == 2'h2) ? BRK_CYC_X1 / 2 : BRK_CYC_X1 / 4;
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst) brk_q <= 0;
      else brk_q <= line_oe ? brk_q + 1 : 0;
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst) hb_q <= 0;
      else hb_q <= hash_busy ? hb_q + 1 : 0;
   // the first load after power-up reads unprogrammed memory, so width is judged after soft reset
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst) arm_q <= 1'b0;
      else if (wb_ack_o && wb_we_i && wb_adr_i == OFS_CTRL && wb_dat_i[CTRL_SRST]) arm_q <= 1'b1;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_needs_req: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
      else $error("ack without request");
   a_ack_in_time: assert property ($rose(wb_cyc_i && wb_stb_i) |-> ##[2:10] wb_ack_o)
      else $error("ack late");
   a_break_low: assert property (line_oe |-> !line_out)
      else $error("break not low");
   a_break_width: assert property (arm_q && $fell(line_oe) |-> brk_q == brk_exp)
      else $error("break width wrong");
   a_hash_steps: assert property ($fell(hash_busy) |-> hb_q == HASH_STEPS)
      else $error("hash step count wrong");
   a_hash_cause: assert property ($rose(hash_busy) |->
      $past(wb_we_i) && $past(wb_adr_i) == OFS_CHAL3)
      else $error("hash started without last challenge byte");
   a_rdata_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o)
      else $error("read data changed without ack");
endmodule // cra_result_reg_a_props

// File: verification/cra_host_line.sv
/*
 host end of the single wire: pull-up, break counter and last break width.
 assumes line_out and line_oe from the engine and the core clock.
*/
`timescale 1ns/1ps
module cra_host_line
(
   input wire logic core_clk, // clock
   input wire logic line_out, // device level
   input wire logic line_oe, // device drive
   output logic wire_lvl, // resolved wire
   output int brk_count, // breaks seen
   output int brk_len // last break width
);
   int run;
   // pull-up holds the released wire high
   assign wire_lvl = line_oe ? line_out : 1'b1;
   initial brk_count = 0;
   initial brk_len = 0;
   initial run = 0;
   always @(posedge core_clk)
   begin
      if (wire_lvl === 1'b0)
         run <= run + 1;
      else if (run != 0)
      begin
         brk_len <= run;
         brk_count <= brk_count + 1;
         run <= 0;
      end
   end
endmodule // cra_host_line

// File: verification/tb_challenge_response_result_reg_a_engine.sv
/*
 self-checking bench for the challenge-response engine, wishbone master in tasks.
 assumes the host line model and the bound checker beside the engine.
*/
`timescale 1ns/1ps
`define CHK(n, g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_challenge_response_result_reg_a_engine;
   import cra_pkg::*;
   localparam int BRK = 8;
   logic core_clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0;
   logic [7:0] adr = 0;
   logic [3:0] sel = 0;
   logic [31:0] dat = 0, wb_dat_o, r;
   logic wb_ack_o, line_out, line_oe, auto_sleep_enable, hash_busy, wire_lvl;
   logic [1:0] device_addr_bits, bus_speed_select;
   logic [7:0] res0, res1;
   int brk_count, brk_len, failures = 0, cmp_count = 0, b0;
   always #50 core_clk = ~core_clk;
   cra_result_reg_a_engine #(.BRK_CYC_X1(BRK), .WR_BUSY_CYC(20), .MAP_ROT(0)) uut (
      .core_clk(core_clk), .nrst(nrst), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .line_out(line_out), .line_oe(line_oe),
      .device_addr_bits(device_addr_bits), .bus_speed_select(bus_speed_select),
      .auto_sleep_enable(auto_sleep_enable), .hash_busy(hash_busy));
   cra_host_line host (.core_clk(core_clk), .line_out(line_out), .line_oe(line_oe),
      .wire_lvl(wire_lvl), .brk_count(brk_count), .brk_len(brk_len));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ack and read data are taken at the rising edge, before that edge's updates land
   task automatic wb(input int w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w[0], a, d, 4'hf};
      @(posedge core_clk);
      while (wb_ack_o !== 1'b1 && n < 50)
      begin
         n++;
         @(posedge core_clk);
      end
      r = wb_dat_o;
      {cyc, stb} <= 2'b00;
      if (n >= 50) failures++;
      @(posedge core_clk);
   endtask
   task automatic wait_brk(input int c);
      int n;
      n = 0;
      while (!(brk_count > c && wire_lvl === 1'b1) && n < 500)
      begin
         n++;
         @(posedge core_clk);
      end
   endtask
   task automatic t_otp;
      wb(1, 8'h40, 32'h9c);
      wb(0, OFS_STAT, 0);
      `CHK("busy_read", r, 32'h0)
      repeat (25) @(posedge core_clk);
      wb(1, 8'h44, 0);
      repeat (25) @(posedge core_clk);
      wb(1, 8'h48, 0);
      repeat (25) @(posedge core_clk);
      wb(0, OFS_STAT, 0);
      `CHK("busy_flag", r[STAT_EEW], 1'b1)
      $display("test otp done");
   endtask
   task automatic t_cfg;
      b0 = brk_count;
      wb(1, OFS_CTRL, 32'h100);
      wait_brk(b0);
      `CHK("ready_break", brk_count, b0 + 1)
      `CHK("break_width", brk_len, BRK)
      `CHK("dev_addr", device_addr_bits, 2'h2)
      `CHK("speed", bus_speed_select, 2'h1)
      `CHK("auto_sleep", auto_sleep_enable, 1'b1)
      wb(0, OFS_CTRL, 0);
      `CHK("ctrl", r[7:0], 8'h9c)
      wb(0, OFS_STAT, 0);
      `CHK("stat", r[7:0], 8'h80)
      $display("test cfg done");
   endtask
   task automatic t_ctrl;
      wb(1, OFS_CTRL, 32'h98);
      `CHK("sleep_off", auto_sleep_enable, 1'b0)
      wb(0, OFS_CTRL, 0);
      `CHK("ctrl_rw", r[7:0], 8'h98)
      wb(1, OFS_STAT, 32'hff);
      wb(0, OFS_STAT, 0);
      `CHK("stat_ro", r[7:0], 8'h80)
      wb(1, OFS_CTRL, 32'h9c);
      $display("test ctrl done");
   endtask
   task automatic result_reg_a(input logic [31:0] ch, output logic [7:0] res);
      int n;
      n = 0;
      wb(1, OFS_SECRET_SELECT_REG, 0);
      for (int i = 0; i < 4; i++)
         wb(1, OFS_CHAL0 + 8'(4 * i), {24'h0, ch[8*i +: 8]});
      `CHK("hash_busy", hash_busy, 1'b1)
      while (hash_busy !== 1'b0 && n < 100)
      begin
         n++;
         @(posedge core_clk);
      end
      wb(0, OFS_RES, 0);
      res = r[7:0];
   endtask
   task automatic t_hash;
      result_reg_a(32'h0, res0);
      `CHK("zero_hash", res0, 8'h00)
      result_reg_a(32'he10f3ca5, res0);
      result_reg_a(32'he10f3ca5, res1);
      `CHK("repeat_hash", res1, res0)
      wb(0, OFS_STAT, 0);
      `CHK("no_error", r[7:0], 8'h80)
      $display("test hash done");
   endtask
   task automatic t_seq;
      b0 = brk_count;
      wb(1, OFS_CHAL3, 32'h5a);
      wait_brk(b0);
      `CHK("err_break", brk_count, b0 + 1)
      wb(0, 8'h30, 0);
      `CHK("unmapped", r, 32'h0)
      wait_brk(b0 + 1);
      `CHK("again_break", brk_count, b0 + 2)
      wb(0, OFS_STAT, 0);
      `CHK("bus_error", r[7:0], 8'h82)
      wb(0, 8'h30, 0);
      repeat (30) @(posedge core_clk);
      `CHK("quiet", brk_count, b0 + 2)
      $display("test seq done");
   endtask
   initial
   begin
      #1000000;
      failures++;
      end_sim();
   end
   initial
   begin
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (10) @(posedge core_clk);
      t_otp();
      t_cfg();
      t_ctrl();
      t_hash();
      t_seq();
      end_sim();
   end
endmodule // tb_challenge_response_result_reg_a_engine
bind cra_result_reg_a_engine cra_result_reg_a_props #(.BRK_CYC_X1(BRK_CYC_X1)) u_props (
   .core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .line_out(line_out), .line_oe(line_oe),
   .bus_speed_select(bus_speed_select), .hash_busy(hash_busy));
